//--- flsm_top.sv
// four-line serial multiplexer: registers, tx scanner, lines, rx silo
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - several ready lines: line 3 first
// - tx holding buffer plus shifter per line
// - idle tx output rests at mark
// - break bit holds its line at zero
// - break keeps normal load and ready timing
// - dtr bits readable, drive dtr outputs
// - dtr cleared by init, not software clear
// - tcr byte or word access
// - no modem interlock with rx or tx
// - carrier and ring bits read-only, live
// - carrier high byte, ring low byte
// - modem changes raise no interrupt
// - chosen line shown in two-bit field
// - tx request on enabled empty line
// - rx characters pass through shared silo
// - rx request at 1 or 16 chars
// - per-line baud, stop, parity, length
// - maintenance mode loops tx to rx
// - break acts per line independently
// - scanner loads field, sets ready, clears
// - rx request beats tx request
// - alarm after 16 pushes, rx read clears
module flsm_top #(
  parameter int SILO_DEPTH = 64, // silo entries
  parameter int BAUD_UNIT  = 16  // clocks per bit per speed step
) (
  input  wire logic        clk,        // 100 MHz clock
  input  wire logic        resetn,     // bus initialize, sync low
  input  wire logic [2:0]  reg_addr,   // register byte address
  input  wire logic [15:0] reg_wdata,  // write data
  input  wire logic [1:0]  reg_be,     // byte enables
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic      [15:0] reg_rdata,  // read data, cycle after strobe
  input  wire logic [3:0]  rx_line_in, // serial inputs
  input  wire logic [3:0]  carrier_in, // carrier detect inputs
  input  wire logic [3:0]  ring_in,    // ring indicator inputs
  output logic      [3:0]  tx_line_out,// serial outputs
  output logic      [3:0]  dtr_out,    // data terminal ready
  output logic             irq,        // any enabled request
  output logic             irq_rx_sel  // request is the receiver one
);
  import flsm_pkg::*;
  localparam int PW = $clog2(SILO_DEPTH);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] per_f(input logic [3:0] spd);
    per_f = 16'(({12'h0, spd} + 16'h1) * 16'(BAUD_UNIT));
  endfunction
  function automatic logic [7:0] msk_f(input logic [1:0] len);
    msk_f = 8'hff >> (2'h3 - len);
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  logic             mse_r, rie_r, sae_r, tie_r, maint_r, clr_r;
  logic             mse_nxt, rie_nxt, sae_nxt, tie_nxt, maint_nxt, clr_nxt;
  logic             tx_ready_flag_r, tx_ready_flag_nxt;
  logic [1:0]       tx_line_number_field_r, tx_line_number_field_nxt;
  logic [3:0]       len_en_r, len_en_nxt, dtr_r, dtr_nxt, brk_r, brk_nxt;
  logic [3:0]       tfull_r, tfull_nxt, stop_r, stop_nxt, par_r, par_nxt;
  logic [3:0]       odd_r, odd_nxt, rxon_r, rxon_nxt;
  logic [1:0]       len_r [NL];
  logic [1:0]       len_nxt [NL];
  logic [3:0]       spd_r [NL];
  logic [3:0]       spd_nxt [NL];
  logic [7:0]       tx_char_buffer_r [NL];
  logic [7:0]       tx_char_buffer_nxt [NL];
  logic [15:0]      rdata_nxt;
  logic             irq_nxt, irq_rx_nxt, rx_req, tx_req;
  logic [3:0]       take_w, tout_w, rdone_w, ack_w;
  logic [3:0][11:0] rent_w;
  logic [11:0]      s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic [11:0]      mem [SILO_DEPTH];
  logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0]      cnt_r, cnt_nxt;
  logic [4:0]       sac_r, sac_nxt;
  logic             sa_r, sa_nxt, push, rx_buffer_register_rd;
  logic [1:0]       sel;
  logic             wr_csr, wr_lpr, wr_tcr, wr_tdr;
  logic [1:0]       lsel;

  // ************************************************************
  // register writes, scanner and read mux
  // ************************************************************
  assign rx_buffer_register_rd = reg_rd && reg_addr == REG_RX_BUFFER_REGISTER;
  always_comb begin
    wr_csr = reg_wr && reg_addr == REG_CSR;
    wr_lpr = reg_wr && reg_addr == REG_RX_BUFFER_REGISTER;
    wr_tcr = reg_wr && reg_addr == REG_TCR;
    wr_tdr = reg_wr && reg_addr == REG_MSR;
    lsel = reg_wdata[LPR_LINE +: 2];
    mse_nxt = mse_r; rie_nxt = rie_r; sae_nxt = sae_r; tie_nxt = tie_r;
    maint_nxt = maint_r; clr_nxt = 1'b0;
    tx_ready_flag_nxt = tx_ready_flag_r; tx_line_number_field_nxt = tx_line_number_field_r;
    len_en_nxt = len_en_r; dtr_nxt = dtr_r; brk_nxt = brk_r;
    stop_nxt = stop_r; par_nxt = par_r; odd_nxt = odd_r; rxon_nxt = rxon_r;
    len_nxt = len_r; spd_nxt = spd_r; tx_char_buffer_nxt = tx_char_buffer_r;
    tfull_nxt = tfull_r & ~take_w; // shifter took the buffer
    if (clr_r) begin // dtr kept
      mse_nxt = 1'b0; rie_nxt = 1'b0; sae_nxt = 1'b0; tie_nxt = 1'b0;
      maint_nxt = 1'b0; tx_ready_flag_nxt = 1'b0; tx_line_number_field_nxt = 2'h0;
      len_en_nxt = NIB_RST; brk_nxt = NIB_RST; tfull_nxt = NIB_RST;
      rxon_nxt = NIB_RST;
    end else begin
      if (wr_csr && reg_be[0]) begin
        maint_nxt = reg_wdata[CSR_MAINT];
        clr_nxt = reg_wdata[CSR_CLR];
        mse_nxt = reg_wdata[CSR_MSE];
        rie_nxt = reg_wdata[CSR_RIE];
      end
      if (wr_csr && reg_be[1]) begin
        sae_nxt = reg_wdata[CSR_SAE];
        tie_nxt = reg_wdata[CSR_TIE];
      end
      // line parameters for the addressed line
      if (wr_lpr && reg_be[0]) begin
        len_nxt[lsel] = reg_wdata[LPR_LEN +: 2];
        stop_nxt[lsel] = reg_wdata[LPR_STOP];
        par_nxt[lsel] = reg_wdata[LPR_PAR];
        odd_nxt[lsel] = reg_wdata[LPR_ODD];
      end
      if (wr_lpr && reg_be[1]) begin
        spd_nxt[lsel] = reg_wdata[LPR_SPD +: 4];
        rxon_nxt[lsel] = reg_wdata[LPR_RXON];
      end
      // each byte lane on its own
      if (wr_tcr && reg_be[0]) len_en_nxt = reg_wdata[3:0];
      if (wr_tcr && reg_be[1]) dtr_nxt = reg_wdata[HI_NIB +: 4];
      // data goes to the line the field names
      if (wr_tdr && reg_be[0] && tx_ready_flag_r) begin
        tx_char_buffer_nxt[tx_line_number_field_r] = reg_wdata[7:0];
        tfull_nxt[tx_line_number_field_r] = 1'b1;
        tx_ready_flag_nxt = 1'b0;
      end
      if (wr_tdr && reg_be[1]) brk_nxt = reg_wdata[HI_NIB +: 4];
      if (tx_ready_flag_r && !len_en_nxt[tx_line_number_field_r]) tx_ready_flag_nxt = 1'b0;
      // scan: last hit is highest line
      if (!tx_ready_flag_r && mse_r) begin
        for (int i = 0; i < NL; i++) begin
          if (len_en_r[i] && !tfull_nxt[i]) begin
            tx_ready_flag_nxt = 1'b1;
            tx_line_number_field_nxt = 2'(i);
          end
        end
      end
    end
    // read mux, data valid only the cycle after the strobe
    rdata_nxt = RD_IDLE;
    if (reg_rd) begin
      if (reg_addr == REG_CSR) begin
        rdata_nxt[CSR_TX_READY_FLAG] = tx_ready_flag_r;
        rdata_nxt[CSR_TIE] = tie_r;
        rdata_nxt[CSR_SA] = sa_r;
        rdata_nxt[CSR_SAE] = sae_r;
        rdata_nxt[CSR_TX_LINE_NUMBER_FIELD +: 2] = tx_line_number_field_r;
        rdata_nxt[CSR_RDONE] = cnt_r != '0;
        rdata_nxt[CSR_RIE] = rie_r;
        rdata_nxt[CSR_MSE] = mse_r;
        rdata_nxt[CSR_CLR] = clr_r;
        rdata_nxt[CSR_MAINT] = maint_r;
      end else if (reg_addr == REG_RX_BUFFER_REGISTER) begin
        if (cnt_r != '0) begin
          rdata_nxt[RB_VALID] = 1'b1;
          rdata_nxt[13:0] = {mem[rp_r][11:10], 2'h0, mem[rp_r][9:0]};
        end
      end else if (reg_addr == REG_TCR) begin
        rdata_nxt[HI_NIB +: 4] = dtr_r;
        rdata_nxt[3:0] = len_en_r;
      end else if (reg_addr == REG_MSR) begin
        // live, read-only, no change detect
        rdata_nxt[HI_NIB +: 4] = filt_r[7:4];
        rdata_nxt[3:0] = filt_r[11:8];
      end
    end
    // receiver alarm or done, then transmitter
    rx_req = rie_r && (sae_r ? sa_r : cnt_r != '0);
    tx_req = tie_r && tx_ready_flag_r;
    irq_nxt = rx_req || tx_req;
    irq_rx_nxt = rx_req;
  end

  // control registers; dtr only by bus initialize
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mse_r <= 1'b0; rie_r <= 1'b0; sae_r <= 1'b0; tie_r <= 1'b0;
      maint_r <= 1'b0; clr_r <= 1'b0; tx_ready_flag_r <= 1'b0; tx_line_number_field_r <= 2'h0;
      len_en_r <= NIB_RST; dtr_r <= NIB_RST; brk_r <= NIB_RST;
      tfull_r <= NIB_RST; stop_r <= NIB_RST; par_r <= NIB_RST;
      odd_r <= NIB_RST; rxon_r <= NIB_RST;
      for (int i = 0; i < NL; i++) begin
        len_r[i] <= 2'h0; spd_r[i] <= 4'h0; tx_char_buffer_r[i] <= 8'h00;
      end
      reg_rdata <= RD_IDLE; dtr_out <= NIB_RST;
      irq <= 1'b0; irq_rx_sel <= 1'b0;
    end else begin
      mse_r <= mse_nxt; rie_r <= rie_nxt; sae_r <= sae_nxt;
      tie_r <= tie_nxt; maint_r <= maint_nxt; clr_r <= clr_nxt;
      tx_ready_flag_r <= tx_ready_flag_nxt; tx_line_number_field_r <= tx_line_number_field_nxt;
      len_en_r <= len_en_nxt; dtr_r <= dtr_nxt; brk_r <= brk_nxt;
      tfull_r <= tfull_nxt; stop_r <= stop_nxt; par_r <= par_nxt;
      odd_r <= odd_nxt; rxon_r <= rxon_nxt;
      len_r <= len_nxt; spd_r <= spd_nxt; tx_char_buffer_r <= tx_char_buffer_nxt;
      reg_rdata <= rdata_nxt;
      dtr_out <= dtr_nxt;
      irq <= irq_nxt; irq_rx_sel <= irq_rx_nxt;
    end
  end

  // ************************************************************
  // input synchronisers: rx, carrier, ring
  // ************************************************************
  always_comb begin
    filt_nxt = filt_r;
    for (int k = 0; k < 12; k++) begin
      if (s2_r[k] == s3_r[k]) filt_nxt[k] = s2_r[k];
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= 12'hfff; s2_r <= 12'hfff; s3_r <= 12'hfff; filt_r <= 12'hfff;
    end else begin
      s1_r <= {ring_in, carrier_in, rx_line_in};
      s2_r <= s1_r; s3_r <= s2_r; filt_r <= filt_nxt;
    end
  end

  // ************************************************************
  // per-line transmitter and receiver
  // ************************************************************
  for (genvar i = 0; i < NL; i++) begin : g_ln
    logic [11:0] tsh_r, tsh_nxt;
    logic [3:0]  tbit_r, tbit_nxt, rbit_r, rbit_nxt, n;
    logic [15:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt, per;
    logic        tbusy_r, tbusy_nxt, tout_r, tout_nxt, take, rin;
    logic [7:0]  rsh_r, rsh_nxt, d;
    logic        rbusy_r, rbusy_nxt, rdone_r, rdone_nxt, rpe_r, rpe_nxt;
    logic [11:0] rent_r, rent_nxt;
    assign take_w[i] = take;
    assign tout_w[i] = tout_r;
    assign rdone_w[i] = rdone_r;
    assign rent_w[i] = rent_r;

    // shifter: start, data, parity, stops
    always_comb begin
      n = 4'({2'h0, len_r[i]}) + LEN_BASE;
      per = per_f(spd_r[i]);
      d = tx_char_buffer_r[i] & msk_f(len_r[i]);
      tsh_nxt = tsh_r; tbit_nxt = tbit_r; tcnt_nxt = tcnt_r;
      tbusy_nxt = tbusy_r; take = 1'b0;
      if (clr_r) begin
        tbusy_nxt = 1'b0;
      end else if (!tbusy_r) begin
        if (tfull_r[i]) begin // buffer frees while shifting
          take = 1'b1;
          tbusy_nxt = 1'b1;
          tcnt_nxt = per;
          tsh_nxt = {3'h7, d, 1'b0};
          if (par_r[i]) tsh_nxt[n + 4'h1] = ^d ^ odd_r[i];
          tbit_nxt = n + 4'h2 + {3'h0, par_r[i]} + {3'h0, stop_r[i]};
        end
      end else if (tcnt_r == 16'h1) begin
        tcnt_nxt = per;
        tsh_nxt = {1'b1, tsh_r[11:1]};
        tbit_nxt = tbit_r - 4'h1;
        if (tbit_r == 4'h1) tbusy_nxt = 1'b0;
      end else begin
        tcnt_nxt = tcnt_r - 16'h1;
      end
      // break only gates the pin
      tout_nxt = !brk_nxt[i] && (!tbusy_nxt || tsh_nxt[0]);
    end

    // receiver samples mid-bit; loopback in maintenance
    always_comb begin
      rin = maint_r ? tout_r : filt_r[i];
      rsh_nxt = rsh_r; rbit_nxt = rbit_r; rcnt_nxt = rcnt_r;
      rbusy_nxt = rbusy_r; rpe_nxt = rpe_r; rent_nxt = rent_r;
      rdone_nxt = rdone_r && !ack_w[i];
      if (clr_r) begin
        rbusy_nxt = 1'b0;
        rdone_nxt = 1'b0;
      end else if (!rbusy_r) begin
        if (rxon_r[i] && !rin) begin
          rbusy_nxt = 1'b1; rbit_nxt = 4'h0; rsh_nxt = 8'h00; rpe_nxt = 1'b0;
          rcnt_nxt = {1'b0, per[15:1]};
        end
      end else if (rcnt_r == 16'h1) begin
        rcnt_nxt = per;
        if (rbit_r == 4'h0) begin
          if (rin) rbusy_nxt = 1'b0; // false start
          else rbit_nxt = 4'h1;
        end else if (rbit_r <= n) begin
          rsh_nxt[3'(rbit_r - 4'h1)] = rin;
          rbit_nxt = rbit_r + 4'h1;
        end else if (par_r[i] && rbit_r == n + 4'h1) begin
          rpe_nxt = rin != (^rsh_r ^ odd_r[i]);
          rbit_nxt = rbit_r + 4'h1;
        end else begin
          rbusy_nxt = 1'b0;
          rdone_nxt = 1'b1;
          rent_nxt = {!rin, rpe_r, 2'(i), rsh_r}; // framing, parity, line, data
        end
      end else begin
        rcnt_nxt = rcnt_r - 16'h1;
      end
    end

    always_ff @(posedge clk) begin
      if (!resetn) begin
        tsh_r <= 12'hfff; tbit_r <= 4'h0; tcnt_r <= 16'h0;
        tbusy_r <= 1'b0; tout_r <= 1'b1;
        rsh_r <= 8'h00; rbit_r <= 4'h0; rcnt_r <= 16'h0; rbusy_r <= 1'b0;
        rdone_r <= 1'b0; rpe_r <= 1'b0; rent_r <= 12'h000;
        tx_line_out[i] <= 1'b1;
      end else begin
        tsh_r <= tsh_nxt; tbit_r <= tbit_nxt; tcnt_r <= tcnt_nxt;
        tbusy_r <= tbusy_nxt; tout_r <= tout_nxt;
        rsh_r <= rsh_nxt; rbit_r <= rbit_nxt; rcnt_r <= rcnt_nxt;
        rbusy_r <= rbusy_nxt; rdone_r <= rdone_nxt; rpe_r <= rpe_nxt;
        rent_r <= rent_nxt;
        tx_line_out[i] <= tout_nxt;
      end
    end
  end

  // ************************************************************
  // shared receive silo and alarm counter
  // ************************************************************
  always_comb begin
    sel = 2'h0;
    for (int i = 0; i < NL; i++) begin
      if (rdone_w[i]) sel = 2'(i);
    end
    push = (|rdone_w) && cnt_r != (PW+1)'(SILO_DEPTH) && !clr_r;
    ack_w = push ? (4'h1 << sel) : 4'h0;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r + (PW+1)'(push);
    if (rx_buffer_register_rd && cnt_r != '0) begin
      rp_nxt = rp_r + 1'b1;
      cnt_nxt = cnt_nxt - 1'b1;
    end
    // rx read clears, a push in that cycle still counts
    sac_nxt = (rx_buffer_register_rd ? 5'h0 : sac_r);
    if (push && sac_nxt != SILO_ALARM) sac_nxt = sac_nxt + 5'h1;
    sa_nxt = (sa_r && !rx_buffer_register_rd) || sac_nxt == SILO_ALARM;
    if (clr_r) begin
      wp_nxt = '0; rp_nxt = '0; cnt_nxt = '0; sac_nxt = 5'h0; sa_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_r <= '0; rp_r <= '0; cnt_r <= '0; sac_r <= 5'h0; sa_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt; rp_r <= rp_nxt; cnt_r <= cnt_nxt;
      sac_r <= sac_nxt; sa_r <= sa_nxt;
    end
  end
  // silo storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= rent_w[sel];
  end
endmodule : flsm_top
`default_nettype wire

//--- flsm_pkg.sv
// constants shared by the four-line serial multiplexer
package flsm_pkg;
  // ************************************************************
  // line count and register offsets (byte addresses)
  // ************************************************************
  localparam int         NL       = 4;
  localparam logic [2:0] REG_CSR  = 3'h0; // control and status
  localparam logic [2:0] REG_RX_BUFFER_REGISTER = 3'h2; // read rx buffer, write line params
  localparam logic [2:0] REG_TCR  = 3'h4; // line enables and dtr
  localparam logic [2:0] REG_MSR  = 3'h6; // read modem status, write tx data/break
  // ************************************************************
  // control and status bit positions
  // ************************************************************
  localparam int CSR_MAINT = 3;
  localparam int CSR_CLR   = 4;
  localparam int CSR_MSE   = 5;
  localparam int CSR_RIE   = 6;
  localparam int CSR_RDONE = 7;
  localparam int CSR_TX_LINE_NUMBER_FIELD = 8;
  localparam int CSR_SAE   = 12;
  localparam int CSR_SA    = 13;
  localparam int CSR_TIE   = 14;
  localparam int CSR_TX_READY_FLAG  = 15;
  // ************************************************************
  // line parameter fields and rx buffer fields
  // ************************************************************
  localparam int LPR_LINE = 0;
  localparam int LPR_LEN  = 3;
  localparam int LPR_STOP = 5;
  localparam int LPR_PAR  = 6;
  localparam int LPR_ODD  = 7;
  localparam int LPR_SPD  = 8;
  localparam int LPR_RXON = 12;
  localparam int RB_VALID = 15;
  localparam int HI_NIB   = 8; // upper-byte nibble of tcr, msr, tdr
  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [3:0]  NIB_RST    = 4'h0;
  localparam logic [15:0] RD_IDLE    = 16'h0000;
  localparam logic [4:0]  SILO_ALARM = 5'h10; // characters per alarm
  localparam logic [3:0]  LEN_BASE   = 4'h5;  // shortest character
endpackage : flsm_pkg

//--- flsm_checker.sv
// port assertions for the four-line serial multiplexer
`timescale 1ns/1ps
`default_nettype none
module flsm_checker
  import flsm_pkg::*;
(
  input wire logic        clk,         // clock
  input wire logic        resetn,      // bus initialize
  input wire logic [2:0]  reg_addr,    // register address
  input wire logic [15:0] reg_wdata,   // write data
  input wire logic [1:0]  reg_be,      // byte enables
  input wire logic        reg_wr,      // write strobe
  input wire logic        reg_rd,      // read strobe
  input wire logic [15:0] reg_rdata,   // read data
  input wire logic [3:0]  tx_line_out, // serial outputs
  input wire logic [3:0]  dtr_out,     // dtr outputs
  input wire logic        irq,         // request
  input wire logic        irq_rx_sel   // rx request chosen
);
  // ************************************************************
  // shadow of break bits, ever-enabled lines and request enables
  // ************************************************************
  logic [3:0] brk_r, brk_nxt, used_r, used_nxt;
  logic [1:0] ie_r, ie_nxt;
  // next shadow values from host writes; clear is taken early on purpose
  always_comb begin
    brk_nxt = brk_r;
    used_nxt = used_r;
    ie_nxt = ie_r;
    if (reg_wr && reg_addr == REG_MSR && reg_be[1]) brk_nxt = reg_wdata[HI_NIB +: 4];
    if (reg_wr && reg_addr == REG_TCR && reg_be[0]) used_nxt = used_r | reg_wdata[3:0];
    if (reg_wr && reg_addr == REG_CSR && reg_be[0]) ie_nxt[0] = reg_wdata[CSR_RIE];
    if (reg_wr && reg_addr == REG_CSR && reg_be[1]) ie_nxt[1] = reg_wdata[CSR_TIE];
    if (reg_wr && reg_addr == REG_CSR && reg_be[0] && reg_wdata[CSR_CLR]) begin
      brk_nxt = NIB_RST;
      ie_nxt = 2'h0;
    end
  end
  // shadow registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      brk_r <= NIB_RST;
      used_r <= NIB_RST;
      ie_r <= 2'h0;
    end else begin
      brk_r <= brk_nxt;
      used_r <= used_nxt;
      ie_r <= ie_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_dtr_write;
    reg_wr && reg_addr == REG_TCR && reg_be[1];
  endsequence
  sequence s_no_enable;
    (ie_r == 2'h0) [*4];
  endsequence
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == RD_IDLE)
    else $error("read data seen outside its cycle");
  a_dtr_follow: assert property (s_dtr_write |=> dtr_out == $past(reg_wdata[HI_NIB +: 4]))
    else $error("dtr output does not follow write");
  a_dtr_hold: assert property (!(reg_wr && reg_addr == REG_TCR && reg_be[1]) |=> $stable(dtr_out))
    else $error("dtr output moved without a write");
  a_break_zero: assert property ((brk_r & $past(brk_r) & tx_line_out) == 4'h0)
    else $error("line under break not at zero");
  a_mark_idle: assert property ((~tx_line_out & ~used_r & ~brk_r & ~$past(brk_r)) == 4'h0)
    else $error("unused line left mark");
  a_rx_over_tx: assert property (irq_rx_sel |-> irq)
    else $error("rx select without request");
  a_irq_quiet: assert property (s_no_enable |-> !irq)
    else $error("request with enables off");
  a_init_idle: assert property (disable iff (1'b0) !resetn |=> tx_line_out == 4'hf
    && dtr_out == NIB_RST && !irq && reg_rdata == RD_IDLE)
    else $error("outputs not idle after initialize");
endmodule // flsm_checker
`default_nettype wire

//--- flsm_line_model.sv
// line-side partner: terminals with a loopback plug and modem levels
`timescale 1ns/1ps
`default_nettype none
module flsm_line_model (
  input  wire logic [3:0] tx_line, // from the device
  input  wire logic       echo_en, // loopback plug fitted
  input  wire logic [3:0] cd_set,  // carrier levels wanted
  input  wire logic [3:0] ri_set,  // ring levels wanted
  output logic      [3:0] rx_line, // to the device
  output logic      [3:0] carrier, // carrier detect
  output logic      [3:0] ring     // ring indicator
);
  // unplugged lines rest at mark like a real idle terminal
  assign rx_line = echo_en ? tx_line : 4'hf;
  assign carrier = cd_set;
  assign ring = ri_set;
endmodule // flsm_line_model
`default_nettype wire

//--- tb_top.sv
// self-checking testbench for the four-line serial multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flsm_pkg::*;
  typedef struct {logic [2:0] a; logic [15:0] e; logic [15:0] m;} flsm_note_t;
  logic        clk, resetn, reg_wr, reg_rd, irq, irq_rx_sel, echo_en;
  logic        rd_d = 1'b0;
  logic [2:0]  reg_addr;
  logic [1:0]  reg_be;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0]  rx_line_in, carrier_in, ring_in, tx_line_out, dtr_out, cd_set, ri_set;
  logic [7:0]  d;
  int          n_mismatch = 0;
  int          checks_done = 0;
  integer      seed = 32'hf753;
  flsm_note_t  nq[$];
  flsm_note_t  nt;
  flsm_top #(.SILO_DEPTH(64), .BAUD_UNIT(2)) i_flsm_top (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_line_in(rx_line_in), .carrier_in(carrier_in), .ring_in(ring_in),
    .tx_line_out(tx_line_out), .dtr_out(dtr_out), .irq(irq), .irq_rx_sel(irq_rx_sel));
  flsm_line_model i_flsm_line_model (
    .tx_line(tx_line_out), .echo_en(echo_en), .cd_set(cd_set), .ri_set(ri_set),
    .rx_line(rx_line_in), .carrier(carrier_in), .ring(ring_in));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ************************************************************
  // bus tasks and comparison
  // ************************************************************
  task automatic cmp(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v, input logic [1:0] be);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_be <= be;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read: note the expectation, then strobe for one cycle
  task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
    nq.push_back('{a, e, m});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d === 1'b1) begin
      nt = nq.pop_front();
      cmp($sformatf("rdata at %0h", nt.a), reg_rdata & nt.m, nt.e & nt.m);
    end
    rd_d <= reg_rd;
  end
  // watchdog
  initial begin
    waitc(20000);
    n_mismatch++;
    end_sim();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_be = 2'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    echo_en = 1'b0;
    cd_set = 4'h0;
    ri_set = 4'h0;
    waitc(5);
    resetn <= 1'b1;
    waitc(1);
    #1;
    cmp("tx_line_out", 16'(tx_line_out), 16'h000f);
    // all lines enabled: two loads each, highest line first
    for (int l = 0; l < NL; l++) wr(REG_RX_BUFFER_REGISTER, 16'h1f18 | 16'(l), 2'b11);
    wr(REG_CSR, 16'h4020, 2'b11);
    wr(REG_TCR, 16'h000f, 2'b01);
    for (int k = 7; k >= 0; k--) begin
      waitc(4);
      rd(REG_CSR, 16'h8000 | 16'(k / 2) << 8, 16'h8300);
      #1;
      cmp("irq", 16'(irq), 16'h0001);
      wr(REG_MSR, 16'(8'($random(seed))), 2'b01);
    end
    waitc(4);
    rd(REG_CSR, 16'h0000, 16'h8000);
    $display("test scan done");
    // line 0 alone: zero char, break, loads keep their schedule
    waitc(800);
    wr(REG_TCR, 16'h0001, 2'b01);
    waitc(4);
    rd(REG_CSR, 16'h8000, 16'h8300);
    wr(REG_MSR, 16'h0000, 2'b01);
    waitc(4);
    rd(REG_CSR, 16'h8000, 16'h8300);
    wr(REG_MSR, 16'h0100, 2'b10);
    wr(REG_MSR, 16'h0055, 2'b01);
    waitc(4);
    rd(REG_CSR, 16'h0000, 16'h8000);
    #1;
    cmp("tx_line_out", 16'(tx_line_out), 16'h000e);
    waitc(400);
    rd(REG_CSR, 16'h8000, 16'h8300);
    #1;
    cmp("tx_line_out", 16'(tx_line_out), 16'h000e);
    wr(REG_MSR, 16'h0000, 2'b10);
    $display("test break done");
    // dtr word and byte access, kept across software clear
    wr(REG_TCR, 16'h0a05, 2'b11);
    #1;
    cmp("dtr_out", 16'(dtr_out), 16'h000a);
    rd(REG_TCR, 16'h0a05, 16'h0f0f);
    wr(REG_TCR, 16'h0500, 2'b10);
    rd(REG_TCR, 16'h0505, 16'h0f0f);
    wr(REG_CSR, 16'h0010, 2'b01);
    waitc(3);
    rd(REG_TCR, 16'h0500, 16'h0f0f);
    rd(REG_CSR, 16'h0000, 16'hc360);
    #1;
    cmp("dtr_out", 16'(dtr_out), 16'h0005);
    cmp("tx_line_out", 16'(tx_line_out), 16'h000f);
    $display("test dtr done");
    // modem status follows random carrier and ring levels
    for (int i = 0; i < 4; i++) begin
      cd_set <= 4'($random(seed));
      ri_set <= 4'($random(seed));
      waitc(8);
      rd(REG_MSR, {4'h0, cd_set, 4'h0, ri_set}, 16'hffff);
      #1;
      cmp("irq", 16'(irq), 16'h0000);
    end
    $display("test modem done");
    // one char on line 3 via maintenance loop, then via the plug
    for (int m = 0; m < 2; m++) begin
      wr(REG_RX_BUFFER_REGISTER, 16'h1f1b, 2'b11);
      echo_en <= 1'(m);
      wr(REG_CSR, (m == 1) ? 16'h4060 : 16'h4068, 2'b11);
      wr(REG_TCR, 16'h0008, 2'b01);
      waitc(4);
      d = 8'($random(seed));
      wr(REG_MSR, {8'h00, d}, 2'b01);
      waitc(400);
      #1;
      cmp("irq_rx_sel", 16'(irq_rx_sel), 16'h0001);
      cmp("irq", 16'(irq), 16'h0001);
      rd(REG_RX_BUFFER_REGISTER, {8'h83, d}, 16'hffff);
      rd(REG_RX_BUFFER_REGISTER, 16'h0000, 16'h8000);
      waitc(4);
      #1;
      cmp("irq_rx_sel", 16'(irq_rx_sel), 16'h0000);
      cmp("irq", 16'(irq), 16'h0001);
      wr(REG_CSR, 16'h0010, 2'b01);
      waitc(3);
    end
    // sixteen chars looped on line 3: alarm request only at the sixteenth
    wr(REG_RX_BUFFER_REGISTER, 16'h1f1b, 2'b11);
    wr(REG_CSR, 16'h1068, 2'b11);
    wr(REG_TCR, 16'h0008, 2'b01);
    waitc(4);
    for (int j = 0; j < 16; j++) begin
      #1;
      if (j == 15) cmp("irq_rx_sel", 16'(irq_rx_sel), 16'h0000);
      wr(REG_MSR, 16'(j), 2'b01);
      waitc(330);
    end
    #1;
    cmp("irq_rx_sel", 16'(irq_rx_sel), 16'h0001);
    rd(REG_CSR, 16'h2080, 16'h2080);
    rd(REG_RX_BUFFER_REGISTER, 16'h8300, 16'hffff);
    waitc(3);
    #1;
    cmp("irq_rx_sel", 16'(irq_rx_sel), 16'h0000);
    $display("test alarm done");
    // second initialize clears dtr
    resetn <= 1'b0;
    waitc(2);
    resetn <= 1'b1;
    waitc(1);
    #1;
    cmp("dtr_out", 16'(dtr_out), 16'h0000);
    $display("test rx and init done");
    end_sim();
  end
endmodule // tb_top
bind flsm_top flsm_checker i_flsm_checker (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_line_out(tx_line_out), .dtr_out(dtr_out), .irq(irq), .irq_rx_sel(irq_rx_sel));
`default_nettype wire
